// ### panel_display_mode_control.sv
/*
 Front-panel display mode control: picks the four-digit readout, drives
 unit and status lamps, idle toggle, panel/remote hand-back, address.
 Assumes synchronous key and sensor inputs, values written by firmware
 over APB, and a remote-bus engine outside that reports its state.
*/
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module panel_display_mode_control
   import panel_pkg::*;
#(
   parameter int LAMP_TEST_CYCLES = LAMP_TEST_CYC,
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic key_rate,
   input wire logic key_trise,
   input wire logic key_idle,
   input wire logic key_return,
   input wire logic [SW_BITS-1:0] addr_switch,
   input wire logic reservoir_low,
   input wire logic bus_remote_req,
   input wire logic bus_servicing,
   output logic [15:0] display_digits,
   output logic lamp_rate,
   output logic lamp_degree,
   output logic lamp_stable,
   output logic lamp_low_res,
   output logic lamp_remote,
   output logic lamp_transact,
   output logic lamp_id,
   output logic [ADDR_BITS-1:0] station_addr,
   output logic station_addr_ok,
   output logic irq
);
   localparam int NKEY = 4;

   logic [NKEY-1:0] key_raw;
   logic [NKEY-1:0] key_clean_ff;
   logic [NKEY-1:0] key_press;
   logic [31:0] lamp_test_cnt_ff;
   logic lamp_test_ff;
   logic idle_ff;
   logic remote_ff;
   logic show_addr_ff;
   logic [31:0] blink_cnt_ff;
   logic blink_ff;
   logic [2:0] ctrl_ff;
   logic [15:0] power_ff;
   logic [15:0] rate_ff;
   logic [15:0] trise_ff;
   logic [EV_NUM-1:0] irq_stat_ff;
   logic [EV_NUM-1:0] irq_mask_ff;
   logic [EV_NUM-1:0] events;
   logic reservoir_low_d_ff;
   logic [ADDR_BITS-1:0] sw_addr;
   logic sw_ok;
   logic remote_req_d_ff;
   show_e nxt_show;
   logic [15:0] nxt_digits;
   logic wr_en;
   logic rd_en;

   assign key_raw = {key_return, key_idle, key_trise, key_rate};

   // Debounce each key: level must hold a full window before it is taken
   genvar gi;
   generate
      for (gi = 0; gi < NKEY; gi++) begin : g_debounce
         logic [31:0] cnt_ff;
         always_ff @(posedge mclk) begin
            if (!reset_n) begin
               cnt_ff <= '0;
               key_clean_ff[gi] <= 1'b0;
            end else if (key_raw[gi] == key_clean_ff[gi]) begin
               cnt_ff <= '0;
            end else if (cnt_ff >= 32'(DEBOUNCE_CYCLES - 1)) begin
               cnt_ff <= '0;
               key_clean_ff[gi] <= key_raw[gi];
            end else begin
               cnt_ff <= cnt_ff + 32'h1;
            end
         end
         always_ff @(posedge mclk) begin
            if (!reset_n) begin
               key_press[gi] <= 1'b0;
            end else begin
               key_press[gi] <= (key_raw[gi] != key_clean_ff[gi]) && !key_clean_ff[gi]
                  && (cnt_ff >= 32'(DEBOUNCE_CYCLES - 1));
            end
         end
      end
   endgenerate

   // Switch bank: low five positions weigh the address; positions 5 and 6 must be off for a valid address, position 7 ignored
   assign sw_addr = addr_switch[ADDR_BITS-1:0];
   assign sw_ok = (sw_addr <= ADDR_MAX) && !addr_switch[SW_UNUSED_LO]
      && !addr_switch[SW_UNUSED_HI];

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         station_addr <= ADDR_DEFAULT;
         station_addr_ok <= 1'b1;
      end else begin
         station_addr <= sw_addr;
         station_addr_ok <= sw_ok;
      end
   end

   // Power-up lamp test
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         lamp_test_cnt_ff <= '0;
         lamp_test_ff <= 1'b1;
      end else if (lamp_test_ff) begin
         if (lamp_test_cnt_ff >= 32'(LAMP_TEST_CYCLES - 1)) begin
            lamp_test_ff <= 1'b0;
         end
         lamp_test_cnt_ff <= lamp_test_cnt_ff + 32'h1;
      end
   end

   // Idle toggle; idle key presses during lamp test are ignored
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         idle_ff <= 1'b0;
      end else if (!lamp_test_ff && key_press[2]) begin
         idle_ff <= !idle_ff;
      end
   end

   // Remote enters on a request edge so hand-back sticks while req stays high
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         remote_req_d_ff <= 1'b0;
         remote_ff <= 1'b0;
      end else begin
         remote_req_d_ff <= bus_remote_req;
         if (remote_ff && key_press[3]) begin
            remote_ff <= 1'b0;
         end else if (ctrl_ff[CTRL_REMOTE] || (bus_remote_req && !remote_req_d_ff)) begin
            remote_ff <= 1'b1;
         end
      end
   end

   // Address view latched by return key in panel mode, cleared by other keys
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         show_addr_ff <= 1'b0;
      end else if (!remote_ff && key_press[3] && !lamp_test_ff) begin
         show_addr_ff <= 1'b1;
      end else if (|key_press[2:0] || remote_ff) begin
         show_addr_ff <= 1'b0;
      end
   end

   // Blink time base for the transaction lamp
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         blink_cnt_ff <= '0;
         blink_ff <= 1'b0;
      end else if (!bus_servicing) begin
         blink_cnt_ff <= '0;
         blink_ff <= 1'b0;
      end else if (blink_cnt_ff >= 32'(BLINK_CYCLES - 1)) begin
         blink_cnt_ff <= '0;
         blink_ff <= !blink_ff;
      end else begin
         blink_cnt_ff <= blink_cnt_ff + 32'h1;
      end
   end

   // Display selection; held rate and trise keys win over the address view
   always_comb begin
      nxt_show = SHOW_POWER;
      if (lamp_test_ff) begin
         nxt_show = SHOW_TEST;
      end else if (idle_ff) begin
         nxt_show = SHOW_BLANK;
      end else if (key_clean_ff[0]) begin
         nxt_show = SHOW_RATE;
      end else if (key_clean_ff[1]) begin
         nxt_show = SHOW_TRISE;
      end else if (show_addr_ff) begin
         nxt_show = SHOW_ADDR;
      end
      case (nxt_show)
         SHOW_TEST: nxt_digits = DISP_ALL_ON;
         SHOW_RATE: nxt_digits = rate_ff;
         SHOW_TRISE: nxt_digits = trise_ff;
         SHOW_ADDR: nxt_digits = {11'h000, station_addr};
         SHOW_BLANK: nxt_digits = DISP_ZERO;
         default: nxt_digits = power_ff;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         display_digits <= DISP_ZERO;
         lamp_rate <= 1'b0;
         lamp_degree <= 1'b0;
         lamp_stable <= 1'b0;
         lamp_id <= 1'b0;
      end else begin
         display_digits <= nxt_digits;
         lamp_rate <= (nxt_show == SHOW_RATE) || lamp_test_ff;
         lamp_degree <= (nxt_show == SHOW_TRISE) || lamp_test_ff;
         lamp_stable <= (nxt_show == SHOW_POWER && ctrl_ff[CTRL_STABLE])
            || lamp_test_ff;
         lamp_id <= (nxt_show == SHOW_ADDR) || lamp_test_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         lamp_low_res <= 1'b0;
         lamp_remote <= 1'b0;
         lamp_transact <= 1'b0;
      end else begin
         lamp_low_res <= reservoir_low || lamp_test_ff;
         lamp_remote <= remote_ff || lamp_test_ff;
         lamp_transact <= (bus_servicing && blink_ff) || lamp_test_ff;
      end
   end

   // APB slave, zero wait states
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ctrl_ff <= '0;
         power_ff <= DISP_ZERO;
         rate_ff <= DISP_ZERO;
         trise_ff <= DISP_ZERO;
         irq_mask_ff <= '0;
      end else if (wr_en) begin
         case (paddr)
            REG_CTRL: ctrl_ff <= pwdata[2:0];
            REG_IRQ_MASK: irq_mask_ff <= pwdata[EV_NUM-1:0];
            REG_POWER: power_ff <= pwdata[15:0];
            REG_RATE: rate_ff <= pwdata[15:0];
            REG_TRISE: trise_ff <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Sticky events; a new event beats a same-cycle clear
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         reservoir_low_d_ff <= 1'b0;
      end else begin
         reservoir_low_d_ff <= reservoir_low;
      end
   end
   assign events = {reservoir_low && !reservoir_low_d_ff, key_press[3], key_press[2]};

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         irq_stat_ff <= '0;
      end else if (wr_en && paddr == REG_IRQ_STAT) begin
         irq_stat_ff <= (irq_stat_ff & ~pwdata[EV_NUM-1:0]) | events;
      end else begin
         irq_stat_ff <= irq_stat_ff | events;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (rd_en) begin
            case (paddr)
               REG_CTRL: prdata <= {29'h0, ctrl_ff[2], ctrl_ff[1], remote_ff};
               REG_STATUS: prdata <= {18'h0, station_addr_ok, station_addr, 6'h00,
                  lamp_test_ff, idle_ff};
               REG_IRQ_STAT: prdata <= {29'h0, irq_stat_ff};
               REG_IRQ_MASK: prdata <= {29'h0, irq_mask_ff};
               REG_POWER: prdata <= {16'h0, power_ff};
               REG_RATE: prdata <= {16'h0, rate_ff};
               REG_TRISE: prdata <= {16'h0, trise_ff};
               default: prdata <= '0;
            endcase
         end
      end
   end

   a_test_ends: assert property (@(posedge mclk) disable iff (!reset_n)
      $fell(lamp_test_ff) |=> display_digits == power_ff || idle_ff
      || key_clean_ff[0] || key_clean_ff[1])
      else $error("display not power after lamp test");
   a_idle_blank: assert property (@(posedge mclk) disable iff (!reset_n)
      idle_ff && !lamp_test_ff |=> display_digits == DISP_ZERO)
      else $error("idle display not blank");
   a_rate_lamp: assert property (@(posedge mclk) disable iff (!reset_n)
      key_clean_ff[0] && !idle_ff && !lamp_test_ff
      |=> lamp_rate && display_digits == $past(rate_ff))
      else $error("rate view wrong");
   a_trise_lamp: assert property (@(posedge mclk) disable iff (!reset_n)
      key_clean_ff[1] && !key_clean_ff[0] && !idle_ff && !lamp_test_ff |=> lamp_degree)
      else $error("degree lamp off");
   a_stable_dark: assert property (@(posedge mclk) disable iff (!reset_n)
      !ctrl_ff[CTRL_STABLE] && !lamp_test_ff |=> !lamp_stable)
      else $error("stable lamp lit early");
   a_low_res: assert property (@(posedge mclk) disable iff (!reset_n)
      reservoir_low |=> lamp_low_res) else $error("low lamp dark");
   a_hand_back: assert property (@(posedge mclk) disable iff (!reset_n)
      remote_ff && key_press[3] |=> ##1 !lamp_remote || lamp_test_ff || ctrl_ff[CTRL_REMOTE])
      else $error("remote not released");
   // Lamps still show the test pattern one cycle after the test flag drops
   a_addr_view: assert property (@(posedge mclk) disable iff (!reset_n)
      lamp_id && !$past(lamp_test_ff)
      |-> display_digits[ADDR_BITS-1:0] == $past(station_addr))
      else $error("id lamp without address");
   a_remote_lamp: assert property (@(posedge mclk) disable iff (!reset_n)
      remote_ff |=> lamp_remote) else $error("remote lamp dark");
   a_blink_off: assert property (@(posedge mclk) disable iff (!reset_n)
      !bus_servicing && !lamp_test_ff |=> !lamp_transact) else $error("blink while idle");
endmodule : panel_display_mode_control
`default_nettype wire

// ### panel_display_mode_control_bench.sv
/*
 Self-checking bench for the panel display mode control block: APB, keys,
 switches, reservoir sensor and the remote host, against a shadow of written registers and fixed expected values.
 Assumes shortened lamp-test, debounce and blink counts.
*/
`timescale 1ns/100ps
`default_nettype none
module panel_display_mode_control_bench;
   import panel_pkg::*;
   localparam int DB = 3;
   localparam int BL = 4;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, q;
   logic pready, pslverr, irq, station_addr_ok, bus_remote_req, bus_servicing;
   logic [3:0] keys = 4'h0;
   logic [7:0] sw = 8'h18;
   logic res_low = 1'b0;
   logic want_remote = 1'b0;
   logic want_service = 1'b0;
   logic [15:0] display_digits;
   logic [6:0] lamps;
   logic [4:0] station_addr;
   logic [31:0] regs [int];
   logic [11:0] rdo [3] = '{REG_POWER, REG_RATE, REG_TRISE};
   logic [7:0] swv [5] = '{8'h1E, 8'h1F, 8'h38, 8'h98, 8'h00};
   int errors = 0;
   int num_checks = 0;
   int seed = 10;
   int ons;

   panel_display_mode_control #(.LAMP_TEST_CYCLES(20), .DEBOUNCE_CYCLES(DB),
      .BLINK_CYCLES(BL)) panel_display_mode_control_inst (
      .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .key_rate(keys[0]), .key_trise(keys[1]),
      .key_idle(keys[2]), .key_return(keys[3]), .addr_switch(sw),
      .reservoir_low(res_low), .bus_remote_req(bus_remote_req),
      .bus_servicing(bus_servicing), .display_digits(display_digits),
      .lamp_rate(lamps[6]), .lamp_degree(lamps[5]), .lamp_stable(lamps[4]),
      .lamp_low_res(lamps[3]), .lamp_remote(lamps[2]), .lamp_transact(lamps[1]),
      .lamp_id(lamps[0]), .station_addr(station_addr),
      .station_addr_ok(station_addr_ok), .irq(irq));

   panel_remote_host #(.LAG(3)) panel_remote_host_inst (
      .mclk(mclk), .reset_n(reset_n), .want_remote(want_remote),
      .want_service(want_service), .bus_remote_req(bus_remote_req),
      .bus_servicing(bus_servicing));

   always #5 mclk = ~mclk;

   task automatic conclude();
      if (errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Called just after a rising edge; waits on pready with no assumed latency
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so a following call never re-drives psel in this step
      @(posedge mclk);
   endtask : apb

   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q);
      regs[a] = d;
   endtask : wreg

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, q);
      chk("read data", q, exp);
   endtask : rd

   task automatic press(input int k, input int cyc);
      keys[k] <= 1'b1;
      repeat (cyc) @(posedge mclk);
      keys[k] <= 1'b0;
      repeat (DB + 6) @(posedge mclk);
   endtask : press

   function automatic logic [31:0] bcd();
      logic [31:0] v;
      v = 32'h0;
      for (int i = 0; i < 4; i++) begin
         v[4*i +: 4] = 4'($unsigned($random(seed)) % 10);
      end
      return v;
   endfunction : bcd

   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      conclude();
   end

   initial begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (5) @(posedge mclk);
      chk("test digits", display_digits, DISP_ALL_ON);
      chk("test lamps", lamps, 7'h7F);
      repeat (30) @(posedge mclk);
      chk("start digits", display_digits, DISP_ZERO);
      chk("start lamps", lamps, 7'h00);
      chk("default address", station_addr, ADDR_DEFAULT);
      for (int i = 0; i < 3; i++) begin
         wreg(rdo[i], bcd());
         rd(rdo[i], regs[rdo[i]]);
      end
      apb(1'b1, 12'h104, 32'hFFFF_FFFF, q);
      rd(12'h104, 32'h0);
      repeat (3) @(posedge mclk);
      chk("power digits", display_digits, regs[REG_POWER]);
      for (int k = 0; k < 2; k++) begin
         keys[k] <= 1'b1;
         repeat (DB + 6) @(posedge mclk);
         chk("held digits", display_digits, regs[k ? REG_TRISE : REG_RATE]);
         chk("held lamps", lamps[6:5], k ? 2'b01 : 2'b10);
         keys[k] <= 1'b0;
         repeat (DB + 6) @(posedge mclk);
         chk("back digits", display_digits, regs[REG_POWER]);
         chk("back lamps", lamps[6:5], 2'b00);
      end
      apb(1'b1, REG_CTRL, 32'h1 << CTRL_STABLE, q);
      repeat (3) @(posedge mclk);
      chk("stable lamp", lamps[4], 1'b1);
      apb(1'b1, REG_CTRL, 32'h0, q);
      repeat (3) @(posedge mclk);
      chk("stable lamp off", lamps[4], 1'b0);
      res_low <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("reservoir lamp", lamps[3], 1'b1);
      chk("masked irq", irq, 1'b0);
      rd(REG_IRQ_STAT, 32'h4);
      apb(1'b1, REG_IRQ_MASK, 32'h4, q);
      repeat (2) @(posedge mclk);
      chk("unmasked irq", irq, 1'b1);
      res_low <= 1'b0;
      apb(1'b1, REG_IRQ_STAT, 32'h4, q);
      repeat (2) @(posedge mclk);
      chk("cleared irq", irq, 1'b0);
      chk("reservoir lamp off", lamps[3], 1'b0);
      want_remote <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("remote lamp", lamps[2], 1'b1);
      want_service <= 1'b1;
      ons = 0;
      repeat (8 * BL) begin
         @(posedge mclk);
         ons += lamps[1];
      end
      chk("blink", ons > 0 && ons < 8 * BL, 1'b1);
      want_service <= 1'b0;
      repeat (8) @(posedge mclk);
      chk("blink stopped", lamps[1], 1'b0);
      press(3, DB + 6);
      chk("remote lamp off", lamps[2], 1'b0);
      chk("no address yet", lamps[0], 1'b0);
      want_remote <= 1'b0;
      press(3, DB + 6);
      chk("id lamp", lamps[0], 1'b1);
      press(0, DB + 6);
      chk("id lamp off", lamps[0], 1'b0);
      press(2, DB + 6);
      chk("idle blank", display_digits, DISP_ZERO);
      rd(REG_STATUS, 32'h1 | (32'(ADDR_DEFAULT) << ST_ADDR_LSB) | (32'h1 << ST_ADDR_OK));
      // A one-cycle bounce must not toggle idle back
      press(2, 1);
      chk("bounce ignored", display_digits, DISP_ZERO);
      press(2, DB + 6);
      chk("idle left", display_digits, regs[REG_POWER]);
      // Firmware-forced remote, released only after the force bit is cleared
      apb(1'b1, REG_CTRL, 32'h1 << CTRL_REMOTE, q);
      repeat (3) @(posedge mclk);
      chk("forced remote lamp", lamps[2], 1'b1);
      rd(REG_CTRL, 32'h1);
      apb(1'b1, REG_CTRL, 32'h0, q);
      press(3, DB + 6);
      chk("forced remote off", lamps[2], 1'b0);
      chk("no address after hand-back", lamps[0], 1'b0);
      rd(REG_IRQ_STAT, 32'h3);
      foreach (swv[i]) begin
         sw <= swv[i];
         repeat (5) @(posedge mclk);
         chk("address", station_addr, swv[i][4:0]);
         chk("address ok", station_addr_ok,
            swv[i][4:0] <= ADDR_MAX && swv[i][6:5] == 2'b00);
      end
      conclude();
   end
endmodule : panel_display_mode_control_bench
`default_nettype wire

// ### panel_pkg.sv
/*
 Package for the front-panel display mode control block: register map,
 field layout, timing constants and display selections.
 Assumes a single 100 MHz clock and a 32-bit APB register bus.
*/
package panel_pkg;
   localparam int CLK_HZ = 100_000_000;
   // Timing in own units
   localparam int LAMP_TEST_MS = 4000;
   localparam int DEBOUNCE_MS = 10;
   localparam int BLINK_MS = 250;
   localparam int LAMP_TEST_CYC = LAMP_TEST_MS * (CLK_HZ / 1000);
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);

   // Register byte offsets
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_IRQ_STAT = 12'h008;
   localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
   localparam logic [11:0] REG_POWER = 12'h010;
   localparam logic [11:0] REG_RATE = 12'h014;
   localparam logic [11:0] REG_TRISE = 12'h018;

   // CTRL fields
   localparam int CTRL_REMOTE = 0;
   localparam int CTRL_SERVICE = 1;
   localparam int CTRL_STABLE = 2;

   // STATUS fields
   localparam int ST_IDLE = 0;
   localparam int ST_LAMP_TEST = 1;
   localparam int ST_ADDR_LSB = 8;
   localparam int ST_ADDR_MSB = 12;
   localparam int ST_ADDR_OK = 13;

   // Interrupt event bits
   localparam int EV_IDLE_KEY = 0;
   localparam int EV_RETURN_KEY = 1;
   localparam int EV_LOW_RES = 2;
   localparam int EV_NUM = 3;

   // Address switches
   localparam int SW_BITS = 8;
   localparam int ADDR_BITS = 5;
   localparam logic [4:0] ADDR_MAX = 5'h1E;
   localparam logic [4:0] ADDR_DEFAULT = 5'h18;
   localparam int SW_UNUSED_LO = 5;
   localparam int SW_UNUSED_HI = 6;
   localparam int SW_FACTORY = 7;

   localparam logic [15:0] DISP_ALL_ON = 16'h8888;
   localparam logic [15:0] DISP_ZERO = 16'h0000;

   typedef enum logic [2:0] {
      SHOW_TEST, SHOW_POWER, SHOW_RATE, SHOW_TRISE, SHOW_ADDR, SHOW_BLANK
   } show_e;
endpackage : panel_pkg

// ### panel_remote_host.sv
/*
 Model of the remote bus controller: raises the remote request and the
 servicing level on command, after a chosen lag, just after a rising edge.
 Assumes the bench holds its commands steady between edges.
*/
`timescale 1ns/100ps
`default_nettype none
module panel_remote_host #(
   parameter int LAG = 1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic want_remote,
   input wire logic want_service,
   output logic bus_remote_req,
   output logic bus_servicing
);
   int wait_cnt;

   // Lag lets the bench play a slow controller as well as a prompt one
   always_ff @(posedge mclk) begin
      if (!reset_n || {want_remote, want_service} == {bus_remote_req, bus_servicing}) begin
         wait_cnt <= 0;
      end else if (wait_cnt < LAG) begin
         wait_cnt <= wait_cnt + 1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         bus_remote_req <= 1'b0;
         bus_servicing <= 1'b0;
      end else if (wait_cnt >= LAG) begin
         bus_remote_req <= want_remote;
         // Requests are only serviced while the device is addressed remotely
         bus_servicing <= want_service & want_remote;
      end
   end
endmodule : panel_remote_host
`default_nettype wire
